// file: hdl/sfp_pkg.sv
/*
 * Shared constants and types of the serial flash protection and status block.
 * Assumes one system clock at 200 MHz and an SPI master on the link pins.
 */
`default_nettype none
package sfp_pkg;
	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FRD  = 8'h0B;
	localparam logic [7:0] OP_PP   = 8'h02;
	localparam logic [7:0] OP_SE   = 8'hD8;
	localparam logic [7:0] OP_BE   = 8'hC7;
	localparam logic [7:0] OP_PD   = 8'hB9;
	localparam logic [7:0] OP_RPP  = 8'h53;
	localparam logic [7:0] OP_FRPP = 8'h5B;
	localparam logic [7:0] OP_PPP  = 8'h52;
	localparam logic [7:0] OP_EPP  = 8'hD5;
	localparam logic [7:0] OP_RDP  = 8'hAB;
	localparam logic [7:0] OP_MID  = 8'h90;
	localparam logic [7:0] OP_JID  = 8'h9F;
	// ----------------------------------------------------------------
	// Status layout, reset values, byte positions
	// ----------------------------------------------------------------
	localparam int         ST_SRP_POS   = 7;
	localparam int         ST_BP_LO_POS = 2;
	localparam logic [2:0] BP_RESET     = 3'h0;
	localparam logic       SRP_RESET    = 1'b0;
	localparam logic [2:0] PIN_RESET    = 3'h6;
	localparam logic [8:0] SR_MIN_BYTES = 9'h002;
	localparam logic [8:0] SE_MIN_BYTES = 9'h004;
	localparam logic [8:0] PP_MIN_BYTES = 9'h006;
	localparam logic [8:0] RD_DATA_BYTE = 9'h004;
	localparam logic [8:0] FR_DATA_BYTE = 9'h005;
	localparam logic [8:0] ID_DATA_BYTE = 9'h004;
	localparam logic [8:0] BYTE_CNT_MAX = 9'h1FF;
	// Identification values are arbitrary
	localparam logic [7:0] MFR_ID       = 8'hA5;
	localparam logic [7:0] DEV_ID       = 8'h3C;
	localparam logic [7:0] TYPE_ID      = 8'h5A;
	localparam logic [7:0] ERASED_BYTE  = 8'hFF;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int PUW_DELAY_NS  = 10000;
	localparam int WCYC_NS       = 5000;
	localparam int PUW_CYCLES    = (PUW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WCYC_CYCLES   = (WCYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       status_protect_bit;
		logic [1:0] rsvd;
		logic [2:0] bp;
		logic       write_enable_latch;
		logic       busy;
	} sfp_status_t;
	typedef struct packed {
		logic [7:0]  op;
		logic [23:0] addr;
		logic [7:0]  data;
		logic [8:0]  nbytes;
		logic        aligned;
	} sfp_frame_t;
	typedef enum logic [2:0] {
		MD_IDLE  = 3'b001,
		MD_CYCLE = 3'b010,
		MD_PDOWN = 3'b100
	} sfp_mode_t;
endpackage
`default_nettype wire

// file: hdl/sfp_region_dec.sv
/*
 * Protected-region decoder: maps block-protect code and sector to protection.
 * Assumes 64K-byte sectors and a density of 8, 16 or 32 Mbit.
 */
`default_nettype none
module sfp_region_dec #(
	parameter int DENSITY_MBIT = 32
) (
	// Protect code and target
	input  wire logic [2:0] bp_i,
	input  wire logic [5:0] sector_i,
	// Decision
	output logic            prot_sector_o,
	output logic            prot_all_o,
	output logic            prot_any_o
);
	// ----------------------------------------------------------------
	// Code map follows sector count
	// ----------------------------------------------------------------
	localparam int         LVL   = (DENSITY_MBIT == 32) ? 6 : (DENSITY_MBIT == 16) ? 5 : 4;
	localparam logic [6:0] NSECT = 7'(1 << LVL);
	logic [6:0] span;
	logic [6:0] sect;

	always_comb begin
		span = (bp_i == 3'h0) ? 7'h00 : 7'(7'h01 << (bp_i - 3'h1));
		sect = {1'b0, sector_i} & (NSECT - 7'h01);
	end
	assign prot_any_o    = (bp_i != 3'h0);
	assign prot_all_o    = (bp_i > 3'(LVL));
	assign prot_sector_o = prot_all_o | (prot_any_o & (sect >= NSECT - span));
endmodule
`default_nettype wire

// file: hdl/sfp_ctrl.sv
/*
 * Instruction framing, status register and write protection of a serial flash.
 * Assumes an SPI mode 0/3 master on the link pins and a supply monitor input.
 */
// What this block does
// - Supply below threshold holds reset; nothing is decoded.
// - During power-up write delay, write-type instructions are rejected.
// - Power-up leaves the write-enable latch at 0.
// - Writes, programs and erases need the write-enable latch set.
// - Write disable and each write cycle clear the latch.
// - Write enable sets the latch.
// - Busy flag is 1 for the whole write cycle.
// - While busy, only status read is answered.
// - In power-down, only release power-down is honoured.
// - Three block-protect bits at S4..S2, non-volatile, written by status write.
// - Status bits 5 and 6 read 0.
// - Status-protect bit with low protect pin locks status writes.
// - Block-protect bits are frozen while locked.
// - Program or erase into the protected region is refused.
// - 32 Mbit code map.
// - 16 Mbit code map.
// - 8 Mbit code map.
// - Frame opens at select fall, opcode first, MSB first, ends at rise.
// - Write-type frames must end on a byte boundary.
// - The listed opcode set is decoded.
// - Reads take three address bytes then stream; programs take data bytes.
// - Fast parameter read has two don't-care, offset and dummy bytes.
// - Release power-down returns the device byte after three dummies.
// - Status write touches only bits 7, 4, 3 and 2.
// - Input sampled on rising clock, output shifted on falling clock.
`default_nettype none
module sfp_ctrl #(
	parameter int DENSITY_MBIT = 32
) (
	// System
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       above_write_inhibit_threshold_i,
	// SPI link
	input  wire logic       spi_clk_i,
	input  wire logic       cs_n_i,
	input  wire logic       serial_in_i,
	input  wire logic       wp_n_i,
	output logic            serial_out_o,
	output logic            serial_out_oe_o,
	// Status view
	output logic [7:0]      status_o
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                 link_rst;
	logic [2:0]           bit_idx;
	logic [8:0]           byte_cnt;
	logic [7:0]           shreg;
	logic [7:0]           next_byte;
	logic                 frame_tgl;
	sfp_pkg::sfp_frame_t  fr;
	sfp_pkg::sfp_status_t st_s1;
	sfp_pkg::sfp_status_t st_s2;
	logic [1:0]           view_s1;
	logic [1:0]           view_s2;
	logic [8:0]           resp;
	logic [2:0]           pin_q1;
	logic [2:0]           pin_q2;
	logic [2:0]           pin_q3;
	logic [2:0]           pin_st;
	logic                 cs_prev;
	logic                 tgl_q1;
	logic                 tgl_q2;
	logic                 tgl_seen;
	logic                 pwr_bad;
	logic                 wp_n_st;
	logic                 take;
	logic [15:0]          puw_cnt;
	logic                 puw_active;
	sfp_pkg::sfp_mode_t   mode;
	logic [15:0]          cyc_cnt;
	logic                 write_enable_latch;
	logic                 status_protect_bit;
	logic [2:0]           bp;
	logic                 busy;
	logic                 wr_ok;
	logic                 prot_sector;
	logic                 prot_all;
	logic                 prot_any;
	logic                 cmd_wel_set;
	logic                 cmd_wel_clr;
	logic                 cmd_sr_wr;
	logic                 cmd_cycle;
	logic                 cmd_pd;
	logic                 cmd_wake;
	logic [1:0]           view;
	logic [15:0]          busy_len;

	// ----------------------------------------------------------------
	// Response byte for the current position of a read frame
	// ----------------------------------------------------------------
	function automatic logic [8:0] resp_byte(
		input logic [7:0]           op,
		input logic [8:0]           n,
		input sfp_pkg::sfp_status_t st
	);
		logic [8:0] r;
		r = 9'h000;
		case (op)
			sfp_pkg::OP_RDSR: r = {n != 9'h000, st};
			sfp_pkg::OP_READ, sfp_pkg::OP_RPP:
				r = {n >= sfp_pkg::RD_DATA_BYTE, sfp_pkg::ERASED_BYTE};
			sfp_pkg::OP_FRD, sfp_pkg::OP_FRPP:
				r = {n >= sfp_pkg::FR_DATA_BYTE, sfp_pkg::ERASED_BYTE};
			sfp_pkg::OP_RDP:
				r = {n >= sfp_pkg::ID_DATA_BYTE, sfp_pkg::DEV_ID};
			sfp_pkg::OP_MID:
				r = {n >= sfp_pkg::ID_DATA_BYTE, n[0] ? sfp_pkg::DEV_ID : sfp_pkg::MFR_ID};
			sfp_pkg::OP_JID: begin
				case (n)
					9'h001:  r = {1'b1, sfp_pkg::MFR_ID};
					9'h002:  r = {1'b1, sfp_pkg::TYPE_ID};
					9'h003:  r = {1'b1, sfp_pkg::DEV_ID};
					default: r = 9'h000;
				endcase
			end
			default: r = 9'h000;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Link side: bit and byte counting, reset while deselected
	// ----------------------------------------------------------------
	assign link_rst  = rst_i | cs_n_i;
	assign next_byte = {shreg[6:0], serial_in_i};

	always_ff @(posedge spi_clk_i or posedge link_rst) begin
		if (link_rst) begin
			bit_idx  <= 3'h0;
			byte_cnt <= 9'h000;
		end else begin
			bit_idx <= bit_idx + 3'h1;
			if (bit_idx == 3'h7 && byte_cnt != sfp_pkg::BYTE_CNT_MAX) begin
				byte_cnt <= byte_cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge spi_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg <= 8'h00;
		end else begin
			shreg <= next_byte;
		end
	end

	// ----------------------------------------------------------------
	// Link side: frame capture, held stable after select rises
	// ----------------------------------------------------------------
	always_ff @(posedge spi_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fr        <= '0;
			frame_tgl <= 1'b0;
		end else begin
			fr.aligned <= (bit_idx == 3'h7);
			if (bit_idx == 3'h0 && byte_cnt == 9'h000) begin
				frame_tgl <= ~frame_tgl;
				fr.nbytes <= 9'h000;
			end
			if (bit_idx == 3'h7) begin
				fr.nbytes <= (byte_cnt == sfp_pkg::BYTE_CNT_MAX) ? byte_cnt
					: byte_cnt + 9'h001;
				if (byte_cnt == 9'h000) begin
					fr.op <= next_byte;
				end else if (byte_cnt <= 9'h003) begin
					fr.addr <= {fr.addr[15:0], next_byte};
				end
				if (byte_cnt == 9'h001) begin
					fr.data <= next_byte;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Link side: status and mode brought over by two flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge spi_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_s1   <= '0;
			st_s2   <= '0;
			view_s1 <= 2'h0;
			view_s2 <= 2'h0;
		end else begin
			st_s1   <= status_o;
			st_s2   <= st_s1;
			view_s1 <= view;
			view_s2 <= view_s1;
		end
	end

	// ----------------------------------------------------------------
	// Link side: output shifted on the falling edge
	// ----------------------------------------------------------------
	always_comb begin
		resp = resp_byte(fr.op, byte_cnt, st_s2);
		if (view_s2[0]) begin
			resp = 9'h000;
		end else if (view_s2[1] && fr.op != sfp_pkg::OP_RDP) begin
			resp = 9'h000;
		end else if (st_s2.busy && fr.op != sfp_pkg::OP_RDSR) begin
			resp = 9'h000;
		end
	end

	always_ff @(negedge spi_clk_i or posedge link_rst) begin
		if (link_rst) begin
			serial_out_oe_o <= 1'b0;
			serial_out_o    <= 1'b0;
		end else begin
			serial_out_oe_o <= resp[8];
			serial_out_o    <= resp[~bit_idx];
		end
	end

	// ----------------------------------------------------------------
	// System side: pin synchronisers, a change counts once stages agree
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_q1 <= sfp_pkg::PIN_RESET;
			pin_q2 <= sfp_pkg::PIN_RESET;
			pin_q3 <= sfp_pkg::PIN_RESET;
			pin_st <= sfp_pkg::PIN_RESET;
		end else begin
			pin_q1 <= {cs_n_i, wp_n_i, above_write_inhibit_threshold_i};
			pin_q2 <= pin_q1;
			pin_q3 <= pin_q2;
			pin_st <= ((pin_q2 ~^ pin_q3) & pin_q3) | ((pin_q2 ^ pin_q3) & pin_st);
		end
	end
	assign pwr_bad = ~pin_st[0];
	assign wp_n_st = pin_st[1];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_prev  <= 1'b1;
			tgl_q1   <= 1'b0;
			tgl_q2   <= 1'b0;
			tgl_seen <= 1'b0;
		end else begin
			cs_prev <= pin_st[2];
			tgl_q1  <= frame_tgl;
			tgl_q2  <= tgl_q1;
			if (pin_st[2] && !cs_prev) begin
				tgl_seen <= tgl_q2;
			end
		end
	end
	assign take = pin_st[2] && !cs_prev && (tgl_q2 != tgl_seen) && !pwr_bad
		&& (fr.nbytes != 9'h000);

	// ----------------------------------------------------------------
	// System side: power-up write delay
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			puw_cnt <= 16'(sfp_pkg::PUW_CYCLES);
		end else if (pwr_bad) begin
			puw_cnt <= 16'(sfp_pkg::PUW_CYCLES);
		end else if (puw_cnt != 16'h0000) begin
			puw_cnt <= puw_cnt - 16'h0001;
		end
	end
	assign puw_active = (puw_cnt != 16'h0000);

	// ----------------------------------------------------------------
	// System side: instruction decode at frame end
	// ----------------------------------------------------------------
	sfp_region_dec #(
		.DENSITY_MBIT (DENSITY_MBIT)
	) u_region (
		.bp_i          (bp),
		.sector_i      (fr.addr[21:16]),
		.prot_sector_o (prot_sector),
		.prot_all_o    (prot_all),
		.prot_any_o    (prot_any)
	);

	assign wr_ok = fr.aligned && write_enable_latch && !puw_active;

	always_comb begin
		cmd_wel_set = 1'b0;
		cmd_wel_clr = 1'b0;
		cmd_sr_wr   = 1'b0;
		cmd_cycle   = 1'b0;
		cmd_pd      = 1'b0;
		cmd_wake    = 1'b0;
		if (take) begin
			unique case (mode)
				sfp_pkg::MD_PDOWN: cmd_wake = (fr.op == sfp_pkg::OP_RDP);
				sfp_pkg::MD_CYCLE: cmd_wake = 1'b0;
				sfp_pkg::MD_IDLE: begin
					case (fr.op)
						sfp_pkg::OP_WREN: cmd_wel_set = fr.aligned && !puw_active;
						sfp_pkg::OP_WRDI: cmd_wel_clr = fr.aligned;
						sfp_pkg::OP_WRSR: cmd_sr_wr = wr_ok && (fr.nbytes >= sfp_pkg::SR_MIN_BYTES)
							&& !(status_protect_bit && !wp_n_st);
						sfp_pkg::OP_PP: cmd_cycle = wr_ok && !prot_sector
							&& (fr.nbytes >= sfp_pkg::PP_MIN_BYTES);
						sfp_pkg::OP_SE: cmd_cycle = wr_ok && !prot_sector
							&& (fr.nbytes >= sfp_pkg::SE_MIN_BYTES);
						sfp_pkg::OP_BE:  cmd_cycle = wr_ok && !prot_any;
						sfp_pkg::OP_PPP: cmd_cycle = wr_ok && !prot_all
							&& (fr.nbytes >= sfp_pkg::PP_MIN_BYTES);
						sfp_pkg::OP_EPP: cmd_cycle = wr_ok && !prot_all;
						sfp_pkg::OP_PD:  cmd_pd = fr.aligned;
						default:         cmd_pd = 1'b0;
					endcase
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// System side: mode and write-cycle timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode <= sfp_pkg::MD_IDLE;
		end else if (pwr_bad) begin
			mode <= sfp_pkg::MD_IDLE;
		end else begin
			unique case (mode)
				sfp_pkg::MD_IDLE: begin
					if (cmd_cycle || cmd_sr_wr) begin
						mode <= sfp_pkg::MD_CYCLE;
					end else if (cmd_pd) begin
						mode <= sfp_pkg::MD_PDOWN;
					end
				end
				sfp_pkg::MD_CYCLE: begin
					if (cyc_cnt == 16'h0001) begin
						mode <= sfp_pkg::MD_IDLE;
					end
				end
				sfp_pkg::MD_PDOWN: begin
					if (cmd_wake) begin
						mode <= sfp_pkg::MD_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cyc_cnt <= 16'h0000;
		end else if (cmd_cycle || cmd_sr_wr) begin
			cyc_cnt <= 16'(sfp_pkg::WCYC_CYCLES);
		end else if (cyc_cnt != 16'h0000) begin
			cyc_cnt <= cyc_cnt - 16'h0001;
		end
	end
	assign busy = (mode == sfp_pkg::MD_CYCLE);

	// ----------------------------------------------------------------
	// System side: write-enable latch and protection bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			write_enable_latch <= 1'b0;
		end else if (pwr_bad) begin
			write_enable_latch <= 1'b0;
		end else if (cmd_wel_set) begin
			write_enable_latch <= 1'b1;
		end else if (cmd_wel_clr || cmd_cycle || cmd_sr_wr) begin
			write_enable_latch <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_protect_bit <= sfp_pkg::SRP_RESET;
			bp  <= sfp_pkg::BP_RESET;
		end else if (cmd_sr_wr) begin
			status_protect_bit <= fr.data[sfp_pkg::ST_SRP_POS];
			bp  <= fr.data[sfp_pkg::ST_BP_LO_POS +: 3];
		end
	end

	// ----------------------------------------------------------------
	// Status register and view for the link side
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= 8'h00;
			view     <= 2'h1;
		end else begin
			status_o <= sfp_pkg::sfp_status_t'{status_protect_bit, 2'h0, bp, write_enable_latch, busy};
			view     <= {mode == sfp_pkg::MD_PDOWN, pwr_bad};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_len <= 16'h0000;
		end else begin
			busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
		end
	end

	AST_PWR_BAD_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_bad |=> !write_enable_latch && !busy)
		else $error("operation active while supply low");
	AST_PUW_NO_WEL: assert property (@(posedge clk_i) disable iff (rst_i)
		puw_active |-> !write_enable_latch)
		else $error("latch set during power-up delay");
	AST_CYCLE_NEEDS_WEL: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy) |-> $past(write_enable_latch) && !write_enable_latch)
		else $error("write cycle started without latch");
	AST_WREN_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
		take && fr.op == sfp_pkg::OP_WREN && fr.aligned && !puw_active
		&& mode == sfp_pkg::MD_IDLE |=> write_enable_latch)
		else $error("write enable did not set latch");
	AST_BUSY_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(busy) && !pwr_bad |-> busy_len == 16'(sfp_pkg::WCYC_CYCLES))
		else $error("busy length wrong");
	AST_BUSY_IGNORES: assert property (@(posedge clk_i) disable iff (rst_i)
		busy |=> !$rose(write_enable_latch) && $stable(bp))
		else $error("instruction acted on while busy");
	AST_PD_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
		mode == sfp_pkg::MD_PDOWN && !(take && fr.op == sfp_pkg::OP_RDP)
		|=> mode == sfp_pkg::MD_PDOWN || pwr_bad)
		else $error("power-down left without release");
	AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		status_o[6:5] == 2'h0)
		else $error("reserved status bits set");
	AST_SRP_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
		!$stable(bp) |-> $past(!status_protect_bit || wp_n_st))
		else $error("protect bits changed while locked");
	AST_OE_READ_ONLY: assert property (@(posedge spi_clk_i) disable iff (link_rst)
		serial_out_oe_o |-> byte_cnt != 9'h000)
		else $error("output driven during opcode");

	COV_WREN: cover property (@(posedge clk_i) disable iff (rst_i) $rose(write_enable_latch));
	COV_SR_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) cmd_sr_wr);
	COV_CYCLE: cover property (@(posedge clk_i) disable iff (rst_i) $fell(busy));
	COV_PDOWN: cover property (@(posedge clk_i) disable iff (rst_i) cmd_wake);
endmodule
`default_nettype wire

// file: sim/sfp_spi_master.sv
/*
 * SPI mode 0 master model that drives the link pins of the flash block.
 * Assumes the bench calls xfer for one frame at a time, with frames apart.
 */
`default_nettype none
module sfp_spi_master (
	// Link pins
	output var logic spi_clk_o,
	output var logic cs_n_o,
	output var logic mosi_o,
	input  wire logic miso_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		spi_clk_o = 1'b0;
		cs_n_o    = 1'b1;
		mosi_o    = 1'b1;
	end
	// Frame of n bits, MSB first; clock stands still outside frames
	task automatic xfer(input logic [39:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi_o = tx[39 - i];
			#16 spi_clk_o = 1'b1;
			rx = {rx[6:0], miso_i};
			#16 spi_clk_o = 1'b0;
		end
		#16 cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
/*
 * Self-checking bench for the flash protection and status block.
 * Assumes the SPI master model and a pulled-down serial output line, so that an
 * undriven output reads 0 and cannot pass for driven data.
 */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i;
	logic       rst_i;
	logic       supply_ok;
	logic       wp_n;
	logic       spi_clk;
	logic       cs_n;
	logic       mosi;
	logic       so;
	logic       so_oe;
	logic [7:0] status;
	logic [7:0] rx;
	tri0        link_do;
	int         errors;
	int         comparisons;
	assign link_do = so_oe ? so : 1'bz;
	sfp_ctrl #(.DENSITY_MBIT(32)) dut_u (
		.clk_i                           (clk_i),
		.rst_i                           (rst_i),
		.above_write_inhibit_threshold_i (supply_ok),
		.spi_clk_i                       (spi_clk),
		.cs_n_i                          (cs_n),
		.serial_in_i                     (mosi),
		.wp_n_i                          (wp_n),
		.serial_out_o                    (so),
		.serial_out_oe_o                 (so_oe),
		.status_o                        (status)
	);
	sfp_spi_master m_u (
		.spi_clk_o (spi_clk),
		.cs_n_o    (cs_n),
		.mosi_o    (mosi),
		.miso_i    (link_do)
	);
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [39:0] tx, input int n);
		m_u.xfer(tx, n, rx);
		repeat (10) @(negedge clk_i);
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 1100 && status[0] !== 1'b0; k++) @(negedge clk_i);
	endtask
	task automatic close_out();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_powerup();
		chk(status, 8'h00);
		send({8'h06, 32'h0}, 8);
		chk(status, 8'h00);
		repeat (2010) @(negedge clk_i);
		send({8'h06, 32'h0}, 8);
		chk(status, 8'h02);
		send({8'h05, 32'h0}, 16);
		chk(rx, 8'h02);
		send({8'h04, 32'h0}, 8);
		chk(status, 8'h00);
		send({8'h06, 32'h0}, 7);
		chk(status, 8'h00);
		$display("test powerup done");
	endtask
	task automatic t_wrsr();
		send({8'h06, 32'h0}, 8);
		send({8'h01, 8'hFF, 24'h0}, 16);
		chk(status & 8'h03, 8'h01);
		send({8'h06, 32'h0}, 8);
		wait_idle();
		chk(status, 8'h9C);
		$display("test status write done");
	endtask
	task automatic t_lock();
		wp_n = 1'b0;
		repeat (4) @(negedge clk_i);
		send({8'h06, 32'h0}, 8);
		send({8'h01, 8'h00, 24'h0}, 16);
		wait_idle();
		chk(status, 8'h9E);
		wp_n = 1'b1;
		repeat (4) @(negedge clk_i);
		send({8'h01, 8'h00, 24'h0}, 16);
		wait_idle();
		chk(status, 8'h00);
		$display("test lock done");
	endtask
	task automatic t_array();
		send({8'h03, 32'h0}, 40);
		chk(rx, 8'hFF);
		send({8'h0B, 32'h0}, 40);
		chk(rx, 8'h00);
		send({8'h06, 32'h0}, 8);
		send({8'h01, 8'h04, 24'h0}, 16);
		wait_idle();
		chk(status, 8'h04);
		send({8'h06, 32'h0}, 8);
		send({8'hD8, 32'h3F000000}, 32);
		chk(status, 8'h06);
		send({8'hD8, 32'h0}, 32);
		chk(status & 8'h03, 8'h01);
		wait_idle();
		chk(status, 8'h04);
		send({8'h06, 32'h0}, 8);
		send({8'h01, 8'h00, 24'h0}, 16);
		wait_idle();
		chk(status, 8'h00);
		$display("test array access done");
	endtask
	task automatic t_pdown();
		send({8'h9F, 32'h0}, 16);
		chk(rx, sfp_pkg::MFR_ID);
		send({8'hB9, 32'h0}, 8);
		send({8'h06, 32'h0}, 8);
		chk(status, 8'h00);
		send({8'hAB, 32'h0}, 40);
		chk(rx, sfp_pkg::DEV_ID);
		send({8'h06, 32'h0}, 8);
		chk(status, 8'h02);
		supply_ok = 1'b0;
		repeat (10) @(negedge clk_i);
		chk(status & 8'h03, 8'h00);
		supply_ok = 1'b1;
		$display("test power-down done");
	endtask
	// Main sequence: inputs change on the falling clock edge
	initial begin
		errors = 0;
		comparisons = 0;
		rst_i = 1'b1;
		supply_ok = 1'b1;
		wp_n = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		t_powerup();
		t_wrsr();
		t_lock();
		t_array();
		t_pdown();
		close_out();
	end
	initial begin
		#80us;
		errors++;
		$display("watchdog expired");
		close_out();
	end
endmodule
`default_nettype wire
